// File: design/pss_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_params.svh"
module pss_channel (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    pss_tb_if.chan          tb,
    input  wire logic [2:0] phase_sel,
    input  wire logic       run_req,
    output logic            running,
    output logic            run_start,
    output logic            ramp_locked,
    output logic            top_gate
);
    pss_pkg::pss_chan_state_t st_q, st_d;
    pss_pkg::pss_period_t     ramp_q, ramp_d, offs;
    logic                     m1_q, m1_d, m2_q, m2_d;
    logic                     start_q, start_d, gate_q, gate_d;
    logic                     restart;
    pss_pkg::pss_period_t     lp_q;

    // phase point in eighths of the timebase period
    function automatic pss_pkg::pss_period_t phase_offset(
        input pss_pkg::pss_period_t per, input logic [2:0] ph);
        logic [18:0] p;
        p = 19'(per) * 19'(ph);
        return p[18:`PSS_PHASE_SHIFT];
    endfunction

    always_comb begin
        offs    = phase_offset(tb.period, phase_sel);
        restart = (tb.count == offs);
        ramp_d  = restart ? 16'h0000 : ramp_q + 16'h0001;
        m1_d    = m1_q;
        m2_d    = m2_q;
        if (restart) begin
            m1_d = (ramp_q + 16'h0001 == tb.period);
            m2_d = m1_q;
        end
        // a new timebase period unlocks the ramp until it settles
        if (tb.period != lp_q) begin
            m1_d = 1'b0;
            m2_d = 1'b0;
        end
        st_d = st_q;
        case (st_q)
            pss_pkg::PSS_CH_OFF: if (run_req && tb.locked) begin
                st_d = pss_pkg::PSS_CH_RUN;
            end
            pss_pkg::PSS_CH_RUN: if (!run_req) begin
                st_d = pss_pkg::PSS_CH_OFF;
            end
            default: st_d = pss_pkg::PSS_CH_OFF;
        endcase
        start_d = (st_q == pss_pkg::PSS_CH_OFF)
                && (st_d == pss_pkg::PSS_CH_RUN);
        // gate falls exactly at the phase point
        // held high until restart so a period change cannot cut it
        gate_d  = (st_d == pss_pkg::PSS_CH_RUN) && !restart
                && (gate_q || (ramp_d >= (tb.period >> 1)));
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_q    <= pss_pkg::PSS_CH_OFF;
            ramp_q  <= 16'h0000;
            m1_q    <= 1'b0;
            m2_q    <= 1'b0;
            start_q <= 1'b0;
            gate_q  <= 1'b0;
            lp_q    <= 16'h0000;
        end else begin
            st_q    <= st_d;
            ramp_q  <= ramp_d;
            m1_q    <= m1_d;
            m2_q    <= m2_d;
            start_q <= start_d;
            gate_q  <= gate_d;
            lp_q    <= tb.period;
        end
    end

    assign running     = (st_q == pss_pkg::PSS_CH_RUN);
    assign run_start   = start_q;
    assign ramp_locked = m1_q & m2_q & (tb.period == lp_q);
    assign top_gate    = gate_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    run_needs_lock_a: assert property ($rose(running) |-> $past(tb.locked))
        else $error("channel entered run without loop lock");
    phase_point_a: assert property (ramp_q == 16'h0000 && $past(resetn)
        |-> $past(tb.count) == phase_offset($past(tb.period),
        $past(phase_sel)))
        else $error("ramp restart away from phase point");
    gate_fall_a: assert property ($fell(top_gate) && running
        |-> ramp_q == 16'h0000)
        else $error("gate fell away from ramp start");
endmodule // pss_channel
`default_nettype wire

// File: design/pss_supervisor.sv
// Behaviour
// - both channels switch in step with an external clock from 250 kHz to 1.25 MHz, referenced to the top gate falling edge.
// - the loop follows the falling edge of the sync input, never the rising.
// - each channel's phase is a fraction of the loop period set by its phase configuration.
// - loss of lock sets the lock-fault bit in the status word and pulls alert low unless masked.
// - writing one to the lock-fault bit clears it.
// - an unmasked lock fault may give a spurious alert at start-up or reset.
// - a channel stays off until the loop reports lock.
// - entering run with an unlocked ramp generator sets the lock-fault bit.
// - with no sync clock a nonzero frequency setting sets the period.
// - a zero setting loaded at power-up, reset command or restore holds PWM off until a sync clock arrives.
// - with a zero setting and no sync clock the loop runs at the lowest oscillator rate.
`timescale 1ns/1ps
`default_nettype none
`include "pss_params.svh"
module pss_supervisor (
    input  wire logic            sys_clk,
    input  wire logic            resetn,
    input  wire logic            sync_pin,
    input  wire logic            sync_drive_en,
    output logic                 sync_out,
    output logic                 sync_oe,
    input  wire logic [15:0]     freq_setting,
    input  wire logic            cfg_load,
    input  wire logic [1:0][2:0] phase_cfg,
    input  wire logic [1:0]      run_req,
    input  wire logic            lock_fault_mask,
    input  wire logic            status_wr,
    input  wire logic [7:0]      status_wr_data,
    output logic [7:0]           maker_status_word,
    output logic                 alert_n,
    output logic                 pll_locked,
    output logic [1:0]           pwm_running,
    output logic [1:0]           top_gate_drive
);
    logic                 mon_fall, mon_present, mon_stable;
    pss_pkg::pss_period_t mon_period;

    pss_pkg::pss_src_t    src;
    pss_pkg::pss_period_t tb_per_q, tb_per_d, tb_cnt_q, tb_cnt_d;
    logic                 lock_q, lock_d, lock_prev_q;
    logic                 wait_q, wait_d;
    logic                 sout_q, sout_d, soe_q;

    logic                 fault_q, fault_d, alert_n_q, alert_n_d;
    logic                 fault_set, fault_clr, lock_loss;

    logic [1:0]           running, run_start, ramp_locked, gate;

    pss_tb_if tb_bus ();

    pss_sync_monitor u_mon (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .sync_pin (sync_pin),
        .fall     (mon_fall),
        .period   (mon_period),
        .present  (mon_present),
        .stable   (mon_stable)
    );

    // timebase: source, period and phase counter
    always_comb begin
        if (mon_present) begin
            src = pss_pkg::PSS_SRC_EXT;
        end else if (freq_setting != 16'h0000) begin
            src = pss_pkg::PSS_SRC_PROG;
        end else begin
            src = pss_pkg::PSS_SRC_VCO;
        end
        case (src)
            pss_pkg::PSS_SRC_EXT:  tb_per_d = mon_period;
            pss_pkg::PSS_SRC_PROG: tb_per_d = freq_setting;
            pss_pkg::PSS_SRC_VCO:  tb_per_d = 16'(`PSS_VCO_LOW_PER);
            default:               tb_per_d = 16'(`PSS_VCO_LOW_PER);
        endcase
        if (src == pss_pkg::PSS_SRC_EXT && mon_fall) begin
            tb_cnt_d = 16'h0000;
        end else if (tb_cnt_q + 16'h0001 >= tb_per_q) begin
            // >= keeps the counter bounded when the period shrinks
            tb_cnt_d = 16'h0000;
        end else begin
            tb_cnt_d = tb_cnt_q + 16'h0001;
        end
        // zero setting loaded: wait for a real sync clock
        if (cfg_load) begin
            wait_d = (freq_setting == 16'h0000);
        end else if (mon_present) begin
            wait_d = 1'b0;
        end else begin
            wait_d = wait_q;
        end
        case (src)
            pss_pkg::PSS_SRC_EXT:  lock_d = mon_stable;
            pss_pkg::PSS_SRC_PROG: lock_d = 1'b1;
            // next wait value, so a zero load drops lock at once
            pss_pkg::PSS_SRC_VCO:  lock_d = ~wait_d;
            default:               lock_d = 1'b0;
        endcase
        // drive the shared line so that it falls at our cycle start
        sout_d = (tb_cnt_d >= (tb_per_q >> 1));
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tb_per_q    <= 16'(`PSS_VCO_LOW_PER);
            tb_cnt_q    <= 16'h0000;
            lock_q      <= 1'b0;
            lock_prev_q <= 1'b0;
            wait_q      <= 1'b0;
            sout_q      <= 1'b0;
            soe_q       <= 1'b0;
        end else begin
            tb_per_q    <= tb_per_d;
            tb_cnt_q    <= tb_cnt_d;
            lock_q      <= lock_d;
            lock_prev_q <= lock_q;
            wait_q      <= wait_d;
            sout_q      <= sout_d;
            soe_q       <= sync_drive_en;
        end
    end

    assign tb_bus.period = tb_per_q;
    assign tb_bus.count  = tb_cnt_q;
    assign tb_bus.locked = lock_q;

    for (genvar i = 0; i < 2; i++) begin : g_ch
        pss_channel u_ch (
            .sys_clk     (sys_clk),
            .resetn      (resetn),
            .tb          (tb_bus),
            .phase_sel   (phase_cfg[i]),
            .run_req     (run_req[i]),
            .running     (running[i]),
            .run_start   (run_start[i]),
            .ramp_locked (ramp_locked[i]),
            .top_gate    (gate[i])
        );
    end

    // lock fault: sticky, set beats clear
    always_comb begin
        lock_loss = lock_prev_q & ~lock_q;
        fault_set = lock_loss | (|(run_start & ~ramp_locked));
        fault_clr = status_wr & status_wr_data[`PSS_FAULT_BIT];
        fault_d   = fault_set | (fault_q & ~fault_clr);
        // a fall of lock right after reset may alert if unmasked
        alert_n_d = ~(fault_q & ~lock_fault_mask);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            fault_q   <= 1'b0;
            alert_n_q <= 1'b1;
        end else begin
            fault_q   <= fault_d;
            alert_n_q <= alert_n_d;
        end
    end

    always_comb begin
        maker_status_word = `PSS_STATUS_RST;
        maker_status_word[`PSS_FAULT_BIT] = fault_q;
    end

    assign alert_n        = alert_n_q;
    assign pll_locked     = lock_q;
    assign pwm_running    = running;
    assign top_gate_drive = gate;
    assign sync_out       = sout_q;
    assign sync_oe        = soe_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    lockloss_fault_a: assert property ($fell(lock_q) |=> fault_q)
        else $error("lock loss did not set the fault bit");
    alert_follow_a: assert property (fault_q && !lock_fault_mask
        |=> !alert_n)
        else $error("unmasked fault did not pull alert low");
    masked_quiet_a: assert property (lock_fault_mask [*2] |-> alert_n)
        else $error("alert low while the fault is masked");
    fault_clear_a: assert property (fault_clr && !fault_set
        |=> !maker_status_word[`PSS_FAULT_BIT])
        else $error("write of one did not clear the fault bit");
    fault_sticky_a: assert property (fault_q && !fault_clr |=> fault_q)
        else $error("fault bit dropped without a clearing write");
    ramp_fault_a: assert property (run_start[0] && !ramp_locked[0]
        ##0 $past(resetn) |=> fault_q)
        else $error("unlocked ramp at run entry not flagged");
    ramp_fault_b_a: assert property (run_start[1] && !ramp_locked[1]
        |=> fault_q)
        else $error("unlocked ramp at run entry not flagged");
    ext_wait_a: assert property (wait_q && $past(wait_q)
        |-> !pll_locked && !$rose(pwm_running[0]))
        else $error("locked while waiting for a sync clock");
    prog_period_a: assert property (!mon_present && freq_setting != 16'h0000
        |=> tb_per_q == $past(freq_setting))
        else $error("free-run period not taken from the setting");
    vco_period_a: assert property (!mon_present && freq_setting == 16'h0000
        |=> tb_per_q == `PSS_VCO_LOW_PER)
        else $error("zero setting without sync not at lowest rate");
    fall_align_a: assert property (mon_present && mon_fall
        |=> tb_cnt_q == 16'h0000)
        else $error("timebase not aligned to sync falling edge");
    off_until_lock_a: assert property (!pll_locked [*3]
        |-> !$rose(pwm_running[1]))
        else $error("channel started without lock");

    lock_loss_c: cover property ($fell(lock_q) ##1 !alert_n);
    ext_run_c: cover property (mon_stable && pll_locked ##1
        $rose(pwm_running[0]));
    clear_c: cover property (fault_q ##1 fault_clr ##1 !fault_q);
    vco_c: cover property (!mon_present && freq_setting == 16'h0000 && !wait_q);
endmodule // pss_supervisor
`default_nettype wire

// File: design/pss_sync_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_params.svh"
module pss_sync_monitor (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic                 sync_pin,
    output logic                      fall,
    output pss_pkg::pss_period_t      period,
    output logic                      present,
    output logic                      stable
);
    logic                 s1_q, s2_q, s3_q;
    pss_pkg::pss_period_t cnt_q, cnt_d, per_q, per_d;
    logic                 pres_q, pres_d, stab_q, stab_d;
    logic                 fall_q, fall_d;
    pss_pkg::pss_period_t len;

    function automatic pss_pkg::pss_period_t absdiff(
        input pss_pkg::pss_period_t a, input pss_pkg::pss_period_t b);
        return (a > b) ? a - b : b - a;
    endfunction

    always_comb begin
        len    = cnt_q + 16'h0001;
        fall_d = s3_q & ~s2_q;
        cnt_d  = fall_d ? 16'h0000
               : (cnt_q > 16'(`PSS_SYNC_PER_MAX)) ? cnt_q : len;
        per_d  = per_q;
        pres_d = pres_q;
        stab_d = stab_q;
        if (fall_d) begin
            per_d  = len;
            pres_d = (len >= 16'(`PSS_SYNC_PER_MIN))
                   && (len <= 16'(`PSS_SYNC_PER_MAX));
            stab_d = pres_d && (absdiff(len, per_q) <= 16'(`PSS_LOCK_TOL));
        end else if (cnt_q > 16'(`PSS_SYNC_PER_MAX)) begin
            // clock stopped: drop presence once the count passes the longest sync period
            pres_d = 1'b0;
            stab_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            s3_q   <= 1'b0;
            cnt_q  <= 16'h0000;
            per_q  <= 16'h0000;
            pres_q <= 1'b0;
            stab_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            s1_q   <= sync_pin;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            cnt_q  <= cnt_d;
            per_q  <= per_d;
            pres_q <= pres_d;
            stab_q <= stab_d;
            fall_q <= fall_d;
        end
    end

    assign fall    = fall_q;
    assign period  = per_q;
    assign present = pres_q;
    assign stable  = stab_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    present_range_a: assert property (present |-> (period >= `PSS_SYNC_PER_MIN
        && period <= `PSS_SYNC_PER_MAX))
        else $error("sync present with period out of range");
    stable_present_a: assert property (stable |-> present)
        else $error("sync stable without presence");
endmodule // pss_sync_monitor
`default_nettype wire

// File: inc/pss_params.svh
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH
`define PSS_CLK_KHZ       25000
`define PSS_SYNC_FMIN_KHZ 250
`define PSS_SYNC_FMAX_KHZ 1250
// longest sync period rounds down, shortest rounds up
`define PSS_SYNC_PER_MAX  (`PSS_CLK_KHZ / `PSS_SYNC_FMIN_KHZ)
`define PSS_SYNC_PER_MIN  ((`PSS_CLK_KHZ + `PSS_SYNC_FMAX_KHZ - 1) / `PSS_SYNC_FMAX_KHZ)
`define PSS_LOCK_TOL      2
`define PSS_VCO_LOW_PER   125
`define PSS_FAULT_BIT     4
`define PSS_STATUS_RST    8'h00
`define PSS_PHASE_SHIFT   3
`endif

// File: inc/pss_pkg.sv
package pss_pkg;
    typedef logic [15:0] pss_period_t;
    typedef enum logic {PSS_CH_OFF, PSS_CH_RUN} pss_chan_state_t;
    typedef enum logic [1:0] {PSS_SRC_EXT, PSS_SRC_PROG, PSS_SRC_VCO} pss_src_t;
endpackage

// File: inc/pss_tb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pss_tb_if;
    pss_pkg::pss_period_t period;
    pss_pkg::pss_period_t count;
    logic                 locked;
    modport src  (output period, output count, output locked);
    modport chan (input period, input count, input locked);
endinterface
`default_nettype wire

// File: verification/pss_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_params.svh"
module pss_supervisor_bench;
    logic             sys_clk        = 1'b0;
    logic             resetn         = 1'b0;
    logic             src_en         = 1'b0;
    logic             sync_drive_en  = 1'b0;
    logic             cfg_load       = 1'b0;
    logic             mask           = 1'b0;
    logic             status_wr      = 1'b0;
    logic [15:0]      half_ns        = 16'h0320;
    logic [15:0]      freq_setting   = 16'h0000;
    logic [1:0][2:0]  phase_cfg      = {3'h4, 3'h0};
    logic [1:0]       run_req        = 2'h0;
    logic [7:0]       status_wr_data = 8'h00;
    wire logic        sync_pin;
    wire logic        src_line;
    wire logic        sync_out;
    wire logic        sync_oe;
    wire logic        alert_n;
    wire logic        pll_locked;
    wire logic [7:0]  maker_status_word;
    wire logic [1:0]  pwm_running;
    wire logic [1:0]  top_gate_drive;
    int               n_errors       = 0;
    int               comparisons    = 0;
    int               cyc            = 0;
    int               p;
    int               a;
    int               b;

    // one driver on the shared line at a time
    assign sync_pin = sync_oe ? sync_out : src_line;

    pss_sync_source src (
        .en        (src_en),
        .half_ns   (half_ns),
        .sync_line (src_line)
    );

    pss_supervisor dut (
        .sys_clk           (sys_clk),
        .resetn            (resetn),
        .sync_pin          (sync_pin),
        .sync_drive_en     (sync_drive_en),
        .sync_out          (sync_out),
        .sync_oe           (sync_oe),
        .freq_setting      (freq_setting),
        .cfg_load          (cfg_load),
        .phase_cfg         (phase_cfg),
        .run_req           (run_req),
        .lock_fault_mask   (mask),
        .status_wr         (status_wr),
        .status_wr_data    (status_wr_data),
        .maker_status_word (maker_status_word),
        .alert_n           (alert_n),
        .pll_locked        (pll_locked),
        .pwm_running       (pwm_running),
        .top_gate_drive    (top_gate_drive)
    );

    always #20 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_lock(input logic lvl, input int lim);
        for (int i = 0; i < lim && pll_locked !== lvl; i++) tick(1);
    endtask

    task automatic wait_fall(input int ch, output int t);
        logic prev;
        prev = top_gate_drive[ch];
        t = 0;
        for (int i = 0; i < 400 && t == 0; i++) begin
            tick(1);
            if (prev === 1'b1 && top_gate_drive[ch] === 1'b0) t = cyc;
            prev = top_gate_drive[ch];
        end
    endtask

    task automatic gate_period(input int ch, output int per);
        int t0;
        int t1;
        wait_fall(ch, t0);
        wait_fall(ch, t1);
        per = t1 - t0;
    endtask

    // caller lets an edge pass before the next write
    task automatic wr_status(input logic [7:0] d);
        status_wr_data = d;
        status_wr = 1'b1;
        tick(1);
        status_wr = 1'b0;
    endtask

    task automatic t_reset_hold;
        check("status", 16'(maker_status_word), 16'h0000);
        check("alert_n", 16'(alert_n), 16'h0001);
        check("sync_oe", 16'(sync_oe), 16'h0000);
        cfg_load = 1'b1;
        tick(1);
        cfg_load = 1'b0;
        run_req = 2'h3;
        tick(300);
        check("pll_locked", 16'(pll_locked), 16'h0000);
        check("pwm_running", 16'(pwm_running), 16'h0000);
        check("top_gate", 16'(top_gate_drive), 16'h0000);
        $display("test reset_hold done");
    endtask

    task automatic t_ext_lock;
        src_en = 1'b1;
        wait_lock(1'b1, 600);
        check("pll_locked", 16'(pll_locked), 16'h0001);
        tick(1);
        check("pwm_running", 16'(pwm_running), 16'h0003);
        tick(400);
        gate_period(0, p);
        check("gate period", 16'(p), 16'h0028);
        wait_fall(0, a);
        wait_fall(1, b);
        check("phase offset", 16'(b - a), 16'h0014);
        wr_status(8'h10);
        check("fault bit", 16'(maker_status_word[`PSS_FAULT_BIT]), 16'h0000);
        tick(1);
        $display("test ext_lock done");
    endtask

    // a period jump breaks lock while the clock stays present
    task automatic t_lose_lock(input logic m, input logic [15:0] h);
        mask = m;
        half_ns = h;
        wait_lock(1'b0, 600);
        check("pll_locked", 16'(pll_locked), 16'h0000);
        tick(1);
        check("fault bit", 16'(maker_status_word[`PSS_FAULT_BIT]), 16'h0001);
        tick(1);
        check("alert_n", 16'(alert_n), 16'(m));
        wait_lock(1'b1, 800);
        check("pll_locked", 16'(pll_locked), 16'h0001);
        check("fault bit", 16'(maker_status_word[`PSS_FAULT_BIT]), 16'h0001);
        wr_status(8'hEF);
        check("fault bit", 16'(maker_status_word[`PSS_FAULT_BIT]), 16'h0001);
        tick(1);
        wr_status(8'h10);
        check("fault bit", 16'(maker_status_word[`PSS_FAULT_BIT]), 16'h0000);
        tick(1);
        check("alert_n", 16'(alert_n), 16'h0001);
        $display("test lose_lock done");
    endtask

    task automatic t_prog_freq;
        run_req = 2'h0;
        src_en = 1'b0;
        freq_setting = 16'h0032;
        tick(300);
        wr_status(8'h10);
        tick(1);
        freq_setting = 16'h003C;
        run_req = 2'h3;
        tick(1);
        check("pwm_running", 16'(pwm_running), 16'h0003);
        tick(1);
        check("fault bit", 16'(maker_status_word[`PSS_FAULT_BIT]), 16'h0001);
        tick(300);
        gate_period(0, p);
        check("gate period", 16'(p), 16'h003C);
        sync_drive_en = 1'b1;
        tick(2);
        check("sync_oe", 16'(sync_oe), 16'h0001);
        sync_drive_en = 1'b0;
        freq_setting = 16'h0000;
        tick(400);
        gate_period(0, p);
        check("gate period", 16'(p), 16'(`PSS_VCO_LOW_PER));
        $display("test prog_freq done");
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        tick(4);
        resetn = 1'b1;
        tick(1);
        t_reset_hold();
        t_ext_lock();
        t_lose_lock(1'b0, 16'h0640);
        t_lose_lock(1'b1, 16'h0320);
        t_prog_freq();
        tally_and_finish();
    end
endmodule // pss_supervisor_bench
`default_nettype wire

// File: verification/pss_sync_source.sv
`timescale 1ns/1ps
`default_nettype none
module pss_sync_source (
    input  wire logic        en,
    input  wire logic [15:0] half_ns,
    output logic             sync_line
);
    // free-running source timed in ns, unrelated in phase to sys_clk
    initial sync_line = 1'b1;
    always begin
        if (en) begin
            #(half_ns) sync_line = ~sync_line;
        end else begin
            // released: line idles high, never at a simulator-chosen level
            sync_line = 1'b1;
            #13;
        end
    end
endmodule // pss_sync_source
`default_nettype wire
